// ---- core/pec_event_counters.sv ----
module pec_event_counters
  import pec_pkg::*;
#(
  parameter int unsigned NUM_CNT = 2,
  parameter int unsigned CNT_W = 48,
  parameter logic WIDE_WRITE = 1'b1,
  parameter logic [PEC_NUM_ARCH-1:0] EVT_UNAVAIL = 7'h00
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [PEC_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] low_input_word_i,
  input wire logic [31:0] high_input_word_i,
  output logic [PEC_RD_W-1:0] reg_rdata_o,
  output logic reg_rd_valid_o,
  // core state
  input wire logic in_c0_i,
  input wire logic halted_i,
  input wire logic stop_clock_pin_i,
  input wire logic thermal_throttle_first_i,
  input wire logic freq_switch_i,
  input wire logic ref_clk_i,
  // retirement events
  input wire logic inst_last_uop_i,
  input wire logic inst_rep_iter_i,
  input wire logic inst_fault_i,
  input wire logic vm_exit_i,
  input wire logic br_retire_i,
  input wire logic br_mispred_i,
  // cache events
  input wire logic llc_ref_i,
  input wire logic llc_miss_i,
  input wire logic llc_other_pf_i,
  // model-specific event occurrence
  input wire logic msp_event_i,
  input wire logic ev_this_core_i,
  input wire logic ev_this_agent_i,
  input wire logic ev_hwpf_i,
  input wire pec_line_e ev_line_i,
  // status
  output logic [PEC_NUM_ARCH-1:0] event_unavail_o
);

  // pin synchronisers: first stage feeds only the second
  logic stop_s1_reg;
  logic stop_s2_reg;
  logic ref_s1_reg;
  logic ref_s2_reg;
  logic ref_prev_reg;
  logic [31:0] evtsel_reg [NUM_CNT];
  logic [PEC_RD_W-1:0] rdata_reg;
  logic [PEC_RD_W-1:0] rdata_next;
  logic rd_valid_reg;
  logic [PEC_NUM_ARCH-1:0] unavail_reg;
  wire logic [CNT_W-1:0] cnt [NUM_CNT];
  wire logic [NUM_CNT-1:0] inc;
  wire logic core_run;
  wire logic ref_tick;
  wire logic inst_ok;
  wire logic [PEC_RD_W-1:0] cap_word;

  function automatic logic addr_is(input logic [PEC_ADDR_W-1:0] a, input logic [PEC_ADDR_W-1:0] base,
                                   input int unsigned idx);
    return a == (base + PEC_ADDR_W'(idx));
  endfunction

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_s1_reg <= 1'b0;
      stop_s2_reg <= 1'b0;
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else begin
      stop_s1_reg <= stop_clock_pin_i;
      stop_s2_reg <= stop_s1_reg;
      ref_s1_reg <= ref_clk_i;
      ref_s2_reg <= ref_s1_reg;
      ref_prev_reg <= ref_s2_reg;
    end
  end

  assign core_run = in_c0_i && !halted_i && !stop_s2_reg && !thermal_throttle_first_i && !freq_switch_i;
  // reference clock must run below half the core rate for every edge to be seen
  assign ref_tick = ref_s2_reg && !ref_prev_reg;
  // vm exit blocks; interrupts do not
  assign inst_ok = inst_last_uop_i && !inst_rep_iter_i && !inst_fault_i && !vm_exit_i;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      wire logic [7:0] evt;
      wire logic [7:0] um;
      wire logic [PEC_NUM_ARCH-1:0] arch_hit;
      wire logic qual_pass;
      wire logic [PEC_CL_W-1:0] cls;
      wire logic legacy_wr;
      wire logic alias_wr;
      wire logic sel_wr;

      assign evt = evtsel_reg[gi][PEC_EVT_MSB:PEC_EVT_LSB];
      assign um = evtsel_reg[gi][PEC_UM_MSB:PEC_UM_LSB];
      assign cls = pec_class(evt);
      assign arch_hit[0] = (evt == PEC_EV_CYCLES) && (um == PEC_UM_NONE) && core_run;
      assign arch_hit[1] = (evt == PEC_EV_INST) && (um == PEC_UM_NONE) && inst_ok;
      assign arch_hit[2] = (evt == PEC_EV_CYCLES) && (um == PEC_UM_REF) && core_run && ref_tick;
      assign arch_hit[3] = (evt == PEC_EV_LLC) && (um == PEC_UM_LLC_REF) && llc_ref_i && !llc_other_pf_i;
      assign arch_hit[4] = (evt == PEC_EV_LLC) && (um == PEC_UM_LLC_MISS) && llc_miss_i && !llc_other_pf_i;
      assign arch_hit[5] = (evt == PEC_EV_BR) && (um == PEC_UM_NONE) && br_retire_i;
      assign arch_hit[6] = (evt == PEC_EV_BR_MISS) && (um == PEC_UM_NONE) && br_retire_i && br_mispred_i;

      pec_qual u_qual (
        .umask_i(um),
        .class_i(cls),
        .ev_this_core_i(ev_this_core_i),
        .ev_this_agent_i(ev_this_agent_i),
        .ev_hwpf_i(ev_hwpf_i),
        .ev_line_i(ev_line_i),
        .pass_o(qual_pass)
      );

      assign inc[gi] = evtsel_reg[gi][PEC_EN_BIT]
                       && ((|(arch_hit & ~EVT_UNAVAIL)) || ((|cls) && msp_event_i && qual_pass));

      assign legacy_wr = reg_wr_i && addr_is(reg_addr_i, PEC_CNT_BASE, gi);
      assign alias_wr = reg_wr_i && WIDE_WRITE && addr_is(reg_addr_i, PEC_ALIAS_BASE, gi);
      assign sel_wr = reg_wr_i && addr_is(reg_addr_i, PEC_EVTSEL_BASE, gi);

      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          evtsel_reg[gi] <= PEC_EVTSEL_RST;
        end else if (sel_wr) begin
          evtsel_reg[gi] <= low_input_word_i;
        end
      end

      pec_counter #(
        .CNT_W(CNT_W)
      ) u_counter (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .legacy_wr_i(legacy_wr),
        .alias_wr_i(alias_wr),
        .low_input_word_i(low_input_word_i),
        .high_input_word_i(high_input_word_i),
        .inc_i(inc[gi]),
        .cnt_o(cnt[gi])
      );
    end
  endgenerate

  assign cap_word = PEC_RD_W'(WIDE_WRITE) << PEC_CAP_WIDE_BIT;

  always_comb begin
    rdata_next = '0;
    if (reg_addr_i == PEC_CAP_ADDR) begin
      rdata_next = cap_word;
    end
    if (reg_addr_i == PEC_AVAIL_ADDR) begin
      rdata_next = PEC_RD_W'(EVT_UNAVAIL);
    end
    for (int i = 0; i < NUM_CNT; i++) begin
      if (addr_is(reg_addr_i, PEC_CNT_BASE, i) || (WIDE_WRITE && addr_is(reg_addr_i, PEC_ALIAS_BASE, i))) begin
        rdata_next = {{(PEC_RD_W-CNT_W){cnt[i][CNT_W-1]}}, cnt[i]};
      end
      if (addr_is(reg_addr_i, PEC_EVTSEL_BASE, i)) begin
        rdata_next = PEC_RD_W'(evtsel_reg[i]);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
      rd_valid_reg <= 1'b0;
      unavail_reg <= '0;
    end else begin
      rdata_reg <= reg_rd_i ? rdata_next : rdata_reg;
      rd_valid_reg <= reg_rd_i;
      unavail_reg <= EVT_UNAVAIL;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rd_valid_o = rd_valid_reg;
  assign event_unavail_o = unavail_reg;

  // checks on counter 0
  wire logic [7:0] evt0 = evtsel_reg[0][PEC_EVT_MSB:PEC_EVT_LSB];
  wire logic [7:0] um0 = evtsel_reg[0][PEC_UM_MSB:PEC_UM_LSB];
  wire logic en0 = evtsel_reg[0][PEC_EN_BIT];
  wire logic wr0 = reg_wr_i && (addr_is(reg_addr_i, PEC_CNT_BASE, 0) || addr_is(reg_addr_i, PEC_ALIAS_BASE, 0));
  wire logic [PEC_CL_W-1:0] cls0 = pec_class(evt0);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_legacy_sext: assert property (reg_wr_i && addr_is(reg_addr_i, PEC_CNT_BASE, 0) |=>
    cnt[0] == {{(CNT_W-32){$past(low_input_word_i[31])}}, $past(low_input_word_i)})
    else $error("legacy write not sign extended");
  a_alias_full: assert property (WIDE_WRITE && reg_wr_i && addr_is(reg_addr_i, PEC_ALIAS_BASE, 0) |=>
    cnt[0] == {$past(high_input_word_i[CNT_W-33:0]), $past(low_input_word_i)})
    else $error("alias write wrong value");
  a_cap_bit: assert property (reg_rd_i && reg_addr_i == PEC_CAP_ADDR |=>
    reg_rd_valid_o && reg_rdata_o[PEC_CAP_WIDE_BIT] == WIDE_WRITE)
    else $error("capability bit wrong");
  a_core_cycle: assert property (en0 && evt0 == PEC_EV_CYCLES && um0 == PEC_UM_NONE && !EVT_UNAVAIL[0]
    && core_run && !wr0 |=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
    else $error("core cycle not counted");
  a_core_halt: assert property (evt0 == PEC_EV_CYCLES && um0 == PEC_UM_NONE && halted_i && !wr0
    |=> $stable(cnt[0]))
    else $error("core cycle counted while halted");
  a_inst_fault: assert property (evt0 == PEC_EV_INST && (inst_fault_i || vm_exit_i || inst_rep_iter_i)
    |-> !inc[0])
    else $error("instruction counted wrongly");
  a_coherency_state_qual_none: assert property (cls0[PEC_CL_COHERENCY_STATE_QUAL] && um0[PEC_UM_COHERENCY_STATE_QUAL_HI:PEC_UM_COHERENCY_STATE_QUAL_LO] == 4'h0 |-> !inc[0])
    else $error("coherency event counted with no state");
  a_pf_reserved: assert property (cls0[PEC_CL_PF] && um0[PEC_UM_PF_HI:PEC_UM_PF_LO] == 2'h2 |-> !inc[0])
    else $error("reserved prefetch code counted");
  a_core_reserved: assert property (cls0[PEC_CL_CORE] && !um0[PEC_UM_CORE_LO] |-> !inc[0])
    else $error("reserved core scope counted");
  a_avail_read: assert property (reg_rd_i && reg_addr_i == PEC_AVAIL_ADDR |=>
    reg_rdata_o == PEC_RD_W'(EVT_UNAVAIL) ##1 event_unavail_o == EVT_UNAVAIL)
    else $error("availability vector wrong");
  a_inst_count: assert property (en0 && evt0 == PEC_EV_INST && um0 == PEC_UM_NONE && !EVT_UNAVAIL[1]
    && inst_last_uop_i && !inst_rep_iter_i && !inst_fault_i && !vm_exit_i && !wr0
    |=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
    else $error("retired instruction not counted");
  a_ref_count: assert property (en0 && evt0 == PEC_EV_CYCLES && um0 == PEC_UM_REF && !EVT_UNAVAIL[2]
    && core_run && ref_tick && !wr0 |=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
    else $error("reference tick not counted");
  a_ref_only: assert property (evt0 == PEC_EV_CYCLES && um0 == PEC_UM_REF && !ref_tick && !wr0
    |=> $stable(cnt[0]))
    else $error("reference count without a tick");
  a_llc_other: assert property (evt0 == PEC_EV_LLC && llc_other_pf_i && !wr0 |=> $stable(cnt[0]))
    else $error("other prefetcher fill counted");
  a_llc_miss: assert property (en0 && evt0 == PEC_EV_LLC && um0 == PEC_UM_LLC_MISS && !EVT_UNAVAIL[4]
    && llc_miss_i && !llc_other_pf_i && !wr0 |=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
    else $error("cache miss not counted");
  a_unavail_block: assert property (evt0 == PEC_EV_LLC && um0 == PEC_UM_LLC_REF
    && EVT_UNAVAIL[3] |-> !inc[0])
    else $error("unavailable event counted");
  a_branch_count: assert property (en0 && evt0 == PEC_EV_BR && um0 == PEC_UM_NONE && !EVT_UNAVAIL[5]
    && br_retire_i && !wr0 |=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
    else $error("retired branch not counted");
  a_mispred_only: assert property (evt0 == PEC_EV_BR_MISS && !br_mispred_i && !wr0 |=> $stable(cnt[0]))
    else $error("predicted branch counted as miss");
  a_sel_write: assert property (reg_wr_i && addr_is(reg_addr_i, PEC_EVTSEL_BASE, 0)
    |=> um0 == $past(low_input_word_i[PEC_UM_MSB:PEC_UM_LSB]))
    else $error("unit mask not stored");
  a_agent_excl: assert property (cls0[PEC_CL_AGENT] && !um0[PEC_UM_AGENT] && !ev_this_agent_i |-> !inc[0])
    else $error("other agent counted");
  a_core_only: assert property (cls0[PEC_CL_CONLY] && en0 && msp_event_i && !wr0
    |=> cnt[0] == $past(cnt[0]) + CNT_W'(1))
    else $error("core-only event not counted");

  c_core_cycle: cover property (en0 && evt0 == PEC_EV_CYCLES && core_run ##1 inc[0]);
  c_alias_write: cover property (reg_wr_i && addr_is(reg_addr_i, PEC_ALIAS_BASE, 0));
  c_qual_count: cover property (en0 && (|pec_class(evt0)) && inc[0]);
  c_ref_tick: cover property (en0 && um0 == PEC_UM_REF && ref_tick);

endmodule // pec_event_counters

// ---- common/pec_pkg.sv ----
package pec_pkg;

  // register port
  localparam int unsigned PEC_ADDR_W = 12;
  localparam logic [11:0] PEC_CNT_BASE = 12'h0c1;
  localparam logic [11:0] PEC_ALIAS_BASE = 12'h4c1;
  localparam logic [11:0] PEC_EVTSEL_BASE = 12'h186;
  localparam logic [11:0] PEC_CAP_ADDR = 12'h345;
  localparam logic [11:0] PEC_AVAIL_ADDR = 12'h0fa;
  localparam int unsigned PEC_WORD_W = 32;
  localparam int unsigned PEC_RD_W = 64;

  // capability register
  localparam int unsigned PEC_CAP_WIDE_BIT = 13;

  // event select register layout
  localparam int unsigned PEC_EVT_LSB = 0;
  localparam int unsigned PEC_EVT_MSB = 7;
  localparam int unsigned PEC_UM_LSB = 8;
  localparam int unsigned PEC_UM_MSB = 15;
  localparam int unsigned PEC_EN_BIT = 22;
  localparam logic [31:0] PEC_EVTSEL_RST = 32'h0000_0000;

  // unit mask sub-fields, positions inside the unit mask byte (bit 15 is byte bit 7)
  localparam int unsigned PEC_UM_CORE_HI = 7;
  localparam int unsigned PEC_UM_CORE_LO = 6;
  localparam int unsigned PEC_UM_AGENT = 5;
  localparam int unsigned PEC_UM_PF_HI = 5;
  localparam int unsigned PEC_UM_PF_LO = 4;
  localparam int unsigned PEC_UM_COHERENCY_STATE_QUAL_HI = 3;
  localparam int unsigned PEC_UM_COHERENCY_STATE_QUAL_LO = 0;
  localparam logic [1:0] PEC_CORE_ALL = 2'h3;
  localparam logic [1:0] PEC_CORE_THIS = 2'h1;
  localparam logic [1:0] PEC_PF_ALL = 2'h3;
  localparam logic [1:0] PEC_PF_ONLY = 2'h1;
  localparam logic [1:0] PEC_PF_EXCL = 2'h0;

  // predefined events
  localparam int unsigned PEC_NUM_ARCH = 7;
  localparam logic [7:0] PEC_EV_CYCLES = 8'h3c;
  localparam logic [7:0] PEC_EV_INST = 8'hc0;
  localparam logic [7:0] PEC_EV_LLC = 8'h2e;
  localparam logic [7:0] PEC_EV_BR = 8'hc4;
  localparam logic [7:0] PEC_EV_BR_MISS = 8'hc5;
  localparam logic [7:0] PEC_UM_NONE = 8'h00;
  localparam logic [7:0] PEC_UM_REF = 8'h01;
  localparam logic [7:0] PEC_UM_LLC_REF = 8'h4f;
  localparam logic [7:0] PEC_UM_LLC_MISS = 8'h41;

  // model-specific events and their qualification classes
  localparam logic [7:0] PEC_EV_L2_LINES = 8'h24;
  localparam logic [7:0] PEC_EV_BUS_TRAN = 8'h70;
  localparam logic [7:0] PEC_EV_CORE_ONLY = 8'h10;
  localparam int unsigned PEC_CL_CORE = 0;
  localparam int unsigned PEC_CL_AGENT = 1;
  localparam int unsigned PEC_CL_PF = 2;
  localparam int unsigned PEC_CL_COHERENCY_STATE_QUAL = 3;
  localparam int unsigned PEC_CL_CONLY = 4;
  localparam int unsigned PEC_CL_W = 5;

  typedef enum logic [3:0] {
    PEC_LINE_I = 4'h1,
    PEC_LINE_S = 4'h2,
    PEC_LINE_E = 4'h4,
    PEC_LINE_M = 4'h8
  } pec_line_e;

  function automatic logic [PEC_CL_W-1:0] pec_class(input logic [7:0] evt);
    logic [PEC_CL_W-1:0] cl;
    cl = '0;
    case (evt)
      PEC_EV_L2_LINES: begin
        cl[PEC_CL_CORE] = 1'b1;
        cl[PEC_CL_PF] = 1'b1;
        cl[PEC_CL_COHERENCY_STATE_QUAL] = 1'b1;
      end
      PEC_EV_BUS_TRAN: begin
        cl[PEC_CL_CORE] = 1'b1;
        cl[PEC_CL_AGENT] = 1'b1;
      end
      PEC_EV_CORE_ONLY: cl[PEC_CL_CONLY] = 1'b1;
      default: cl = '0;
    endcase
    return cl;
  endfunction

endpackage

// ---- core/pec_qual.sv ----
module pec_qual
  import pec_pkg::*;
(
  // selection
  input wire logic [7:0] umask_i,
  input wire logic [PEC_CL_W-1:0] class_i,
  // occurrence attributes
  input wire logic ev_this_core_i,
  input wire logic ev_this_agent_i,
  input wire logic ev_hwpf_i,
  input wire pec_line_e ev_line_i,
  // result
  output logic pass_o
);

  wire logic [1:0] core_sel;
  wire logic [1:0] pf_sel;
  wire logic core_only;
  wire logic core_ok;
  wire logic agent_ok;
  wire logic pf_ok;
  wire logic coherency_state_qual_ok;

  assign core_sel = umask_i[PEC_UM_CORE_HI:PEC_UM_CORE_LO];
  assign pf_sel = umask_i[PEC_UM_PF_HI:PEC_UM_PF_LO];
  assign core_only = class_i[PEC_CL_CONLY];
  assign core_ok = !class_i[PEC_CL_CORE] || core_only || (core_sel == PEC_CORE_ALL)
                   || ((core_sel == PEC_CORE_THIS) && ev_this_core_i);
  assign agent_ok = !class_i[PEC_CL_AGENT] || core_only || umask_i[PEC_UM_AGENT] || ev_this_agent_i;
  assign pf_ok = !class_i[PEC_CL_PF] || class_i[PEC_CL_AGENT] || (pf_sel == PEC_PF_ALL)
                 || ((pf_sel == PEC_PF_ONLY) && ev_hwpf_i) || ((pf_sel == PEC_PF_EXCL) && !ev_hwpf_i);
  assign coherency_state_qual_ok = !class_i[PEC_CL_COHERENCY_STATE_QUAL] || (|(umask_i[PEC_UM_COHERENCY_STATE_QUAL_HI:PEC_UM_COHERENCY_STATE_QUAL_LO] & ev_line_i));
  assign pass_o = core_ok && agent_ok && pf_ok && coherency_state_qual_ok;

endmodule // pec_qual

// ---- core/pec_counter.sv ----
module pec_counter
  import pec_pkg::*;
#(
  parameter int unsigned CNT_W = 48
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // writes
  input wire logic legacy_wr_i,
  input wire logic alias_wr_i,
  input wire logic [31:0] low_input_word_i,
  input wire logic [31:0] high_input_word_i,
  // counting
  input wire logic inc_i,
  output logic [CNT_W-1:0] cnt_o
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  wire logic [CNT_W-1:0] legacy_val;
  wire logic [CNT_W-1:0] alias_val;
  wire logic [CNT_W-1:0] one;

  assign one = {{(CNT_W-1){1'b0}}, 1'b1};
  assign legacy_val = {{(CNT_W-PEC_WORD_W){low_input_word_i[PEC_WORD_W-1]}}, low_input_word_i};
  assign alias_val = {high_input_word_i[CNT_W-PEC_WORD_W-1:0], low_input_word_i};
  // a write in the same cycle as an event takes precedence; that event is dropped
  assign cnt_next = alias_wr_i ? alias_val : legacy_wr_i ? legacy_val : inc_i ? cnt_reg + one : cnt_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cnt_o = cnt_reg;

endmodule // pec_counter

// ---- sim/pec_core_model.sv ----
module pec_core_model
  import pec_pkg::*;
#(
  parameter int unsigned REF_N = 6
) (
  // clock
  input wire logic core_clk_i,
  // stimulus
  input wire logic fire_i,
  input wire logic [12:0] vec_i,
  input wire pec_line_e line_i,
  input wire logic ref_go_i,
  // event sources
  output logic [12:0] ev_o,
  output pec_line_e line_o,
  output logic ref_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // pulse lines idle low; qualifier bits idle inverted and the line state rotated, so a stale value never passes as valid
  localparam logic [12:0] PULSE = 13'h2d1;
  always @(posedge core_clk_i) begin
    ev_o <= fire_i ? vec_i : (~vec_i & ~PULSE);
    line_o <= fire_i ? line_i : pec_line_e'({line_i[0], line_i[3:1]});
  end
  // reference clock stands still outside a burst; phase unrelated to the core clock
  initial ref_clk_o = 1'b0;
  always @(posedge ref_go_i) begin
    repeat (REF_N) begin
      #57 ref_clk_o = 1'b1;
      #43 ref_clk_o = 1'b0;
    end
  end
endmodule // pec_core_model

// ---- sim/tb_pec_event_counters.sv ----
module tb_pec_event_counters;
  import pec_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] UNAVAIL = 7'h08;
  localparam int unsigned REF_N = 6;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, in_c0 = 0, fire = 0, ref_go = 0, ref_clk, rd_valid;
  logic [3:0] blk = 4'h0;
  logic [11:0] addr = 12'h000;
  logic [31:0] lo = 32'h0, hi = 32'h0;
  logic [12:0] vec = 13'h0, ev;
  logic [63:0] rdata;
  logic [6:0] unavail;
  pec_line_e line = PEC_LINE_M, ev_line;
  int fail_count = 0, tests_run = 0, cycles = 0;

  always #20 core_clk = ~core_clk;

  pec_event_counters #(.NUM_CNT(2), .CNT_W(48), .WIDE_WRITE(1'b1), .EVT_UNAVAIL(UNAVAIL)) i_dut (
    .core_clk_i(core_clk), .rst_i(rst), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
    .low_input_word_i(lo), .high_input_word_i(hi), .reg_rdata_o(rdata), .reg_rd_valid_o(rd_valid),
    .in_c0_i(in_c0), .halted_i(blk[0]), .stop_clock_pin_i(blk[1]), .thermal_throttle_first_i(blk[2]),
    .freq_switch_i(blk[3]), .ref_clk_i(ref_clk), .inst_last_uop_i(ev[0]), .inst_rep_iter_i(ev[1]),
    .inst_fault_i(ev[2]), .vm_exit_i(ev[3]), .br_retire_i(ev[4]), .br_mispred_i(ev[5]), .llc_ref_i(ev[6]),
    .llc_miss_i(ev[7]), .llc_other_pf_i(ev[8]), .msp_event_i(ev[9]), .ev_this_core_i(ev[10]),
    .ev_this_agent_i(ev[11]), .ev_hwpf_i(ev[12]), .ev_line_i(ev_line), .event_unavail_o(unavail)
  );

  pec_core_model #(.REF_N(REF_N)) i_core (
    .core_clk_i(core_clk), .fire_i(fire), .vec_i(vec), .line_i(line), .ref_go_i(ref_go),
    .ev_o(ev), .line_o(ev_line), .ref_clk_o(ref_clk)
  );

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // strobes drop and a cycle passes, so back-to-back calls never drive a strobe twice at once
  task automatic wr(input logic [11:0] a, input logic [31:0] l, input logic [31:0] h);
    reg_wr = 1'b1;
    addr = a;
    lo = l;
    hi = h;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [63:0] exp, input logic [63:0] m = '1);
    reg_rd = 1'b1;
    addr = a;
    step(1);
    reg_rd = 1'b0;
    chk("read valid", 64'h1, {63'h0, rd_valid});
    chk($sformatf("read %h", a), exp, rdata & m);
    step(1);
  endtask

  task automatic run_case(input logic [7:0] es, input logic [7:0] um, input logic [12:0] v, input pec_line_e ln,
                          input logic [63:0] exp);
    wr(PEC_CNT_BASE, 32'h0, 32'h0);
    wr(PEC_EVTSEL_BASE, {16'h0040, um, es}, 32'h0);
    vec = v;
    line = ln;
    fire = 1'b1;
    step(3);
    fire = 1'b0;
    step(3);
    rd(PEC_CNT_BASE, exp);
  endtask

  // blocker settles first, since the stop-clock pin lags through its synchroniser
  task automatic run_core(input logic [3:0] b, input logic [63:0] exp);
    blk = b;
    step(4);
    in_c0 = 1'b1;
    step(10);
    in_c0 = 1'b0;
    step(4);
    blk = 4'h0;
    rd(PEC_CNT_BASE, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      $display("mismatch cycle limit expected 3000 seen %0d", cycles);
      tally_and_finish();
    end
  end

  initial begin
    step(2);
    rst = 1'b0;
    step(1);
    chk("unavail", {57'h0, UNAVAIL}, {57'h0, unavail});
    rd(PEC_AVAIL_ADDR, {57'h0, UNAVAIL});
    rd(PEC_CAP_ADDR, 64'h2000, 64'h2000);
    rd(12'h7ff, 64'h0);
    $display("status test done");
    wr(PEC_CNT_BASE, 32'h8000_0000, 32'h1234_5678);
    rd(PEC_CNT_BASE, 64'hffff_ffff_8000_0000);
    wr(PEC_CNT_BASE + 12'h1, 32'h7fff_ffff, 32'hffff_ffff);
    rd(PEC_CNT_BASE + 12'h1, 64'h0000_0000_7fff_ffff);
    wr(PEC_ALIAS_BASE, 32'h1122_3344, 32'h0000_8abc);
    rd(PEC_CNT_BASE, 64'hffff_8abc_1122_3344);
    wr(PEC_ALIAS_BASE + 12'h1, 32'hcafe_0001, 32'hffff_1234);
    rd(PEC_CNT_BASE + 12'h1, 64'h0000_1234_cafe_0001);
    wr(PEC_EVTSEL_BASE + 12'h1, 32'h0040_cf24, 32'hffff_ffff);
    rd(PEC_EVTSEL_BASE + 12'h1, 64'h0000_0000_0040_cf24);
    $display("write test done");
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    chk("unavail after reset", {57'h0, UNAVAIL}, {57'h0, unavail});
    rd(PEC_CNT_BASE, 64'h0);
    rd(PEC_CNT_BASE + 12'h1, 64'h0);
    rd(PEC_EVTSEL_BASE + 12'h1, 64'h0);
    $display("reset test done");
    wr(PEC_CNT_BASE, 32'h0, 32'h0);
    wr(PEC_EVTSEL_BASE, {16'h0040, PEC_UM_NONE, PEC_EV_CYCLES}, 32'h0);
    run_core(4'h0, 64'd10);
    for (int i = 0; i < 4; i++) begin
      run_core(4'h1 << i, 64'd10);
    end
    wr(PEC_CNT_BASE, 32'h0, 32'h0);
    wr(PEC_EVTSEL_BASE, {16'h0040, PEC_UM_REF, PEC_EV_CYCLES}, 32'h0);
    in_c0 = 1'b1;
    ref_go = 1'b1;
    step(1);
    ref_go = 1'b0;
    step(20);
    in_c0 = 1'b0;
    step(4);
    rd(PEC_CNT_BASE, 64'(REF_N));
    $display("cycle test done");
    run_case(PEC_EV_INST, PEC_UM_NONE, 13'h001, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_INST, PEC_UM_NONE, 13'h003, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_INST, PEC_UM_NONE, 13'h005, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_INST, PEC_UM_NONE, 13'h009, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_BR, PEC_UM_NONE, 13'h010, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_BR_MISS, PEC_UM_NONE, 13'h030, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_BR_MISS, PEC_UM_NONE, 13'h010, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_LLC, PEC_UM_LLC_MISS, 13'h080, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_LLC, PEC_UM_LLC_MISS, 13'h180, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_LLC, PEC_UM_LLC_REF, 13'h040, PEC_LINE_M, 64'd0);
    $display("predefined event test done");
    run_case(PEC_EV_L2_LINES, 8'h4f, 13'h0600, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_L2_LINES, 8'h4f, 13'h0200, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_L2_LINES, 8'hcf, 13'h0200, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_L2_LINES, 8'h8f, 13'h0600, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_L2_LINES, 8'h0f, 13'h0600, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_L2_LINES, 8'h4f, 13'h1600, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_L2_LINES, 8'h5f, 13'h1600, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_L2_LINES, 8'h5f, 13'h0600, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_L2_LINES, 8'h7f, 13'h1600, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_L2_LINES, 8'h6f, 13'h1600, PEC_LINE_M, 64'd0);
    for (int i = 0; i < 4; i++) begin
      run_case(PEC_EV_L2_LINES, 8'h40 | (8'h1 << i), 13'h0600, pec_line_e'(4'h1 << i), 64'd3);
      run_case(PEC_EV_L2_LINES, 8'h40 | (8'h1 << i), 13'h0600, pec_line_e'(4'h1 << ((i + 1) % 4)), 64'd0);
    end
    run_case(PEC_EV_L2_LINES, 8'h40, 13'h0600, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_BUS_TRAN, 8'h40, 13'h0600, PEC_LINE_M, 64'd0);
    run_case(PEC_EV_BUS_TRAN, 8'h40, 13'h0e00, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_BUS_TRAN, 8'h60, 13'h0600, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_BUS_TRAN, 8'h40, 13'h1e00, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_CORE_ONLY, 8'h00, 13'h0200, PEC_LINE_M, 64'd3);
    run_case(PEC_EV_CORE_ONLY, 8'h40, 13'h0200, PEC_LINE_M, 64'd3);
    $display("qualification test done");
    tally_and_finish();
  end
endmodule // tb_pec_event_counters
